// File: include/eoc_irq_pkg.sv
package eoc_irq_pkg;

    // three bits so the fault count stays clear of the sense bit
    localparam int          FAULT_W       = 3;

    localparam logic [11:0] CFG_OFFSET    = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    localparam int          CFG_FC_LSB    = 0;
    localparam int          CFG_SENSE_BIT = 3;
    localparam int          CFG_LATCH_BIT = 4;
    localparam int          CFG_LE_LSB    = 8;

    localparam int          ST_OVER_BIT   = 0;
    localparam int          ST_UNDER_BIT  = 1;
    localparam int          ST_READY_BIT  = 2;
    localparam int          ST_IRQ_BIT    = 3;

    localparam logic [1:0]  EOC_CODE      = 2'h3;
    localparam logic [1:0]  MODE_SHUTDOWN = 2'h0;

    typedef struct packed {
        logic [1:0]         low_limit_exp_msbs;
        logic               latch_style;
        logic               out_sense_sel;
        logic [FAULT_W-1:0] fault_count;
    } cfg_type;

    localparam cfg_type     CFG_RESET     = '{2'h0, 1'h0, 1'h0, '0};

    typedef struct packed {
        logic done;
        logic above;
        logic below;
    } conv_type;

endpackage

// File: verilog/fault_counter.sv
module fault_counter #(
    parameter int CNT_W = 4
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic             ce,
    input  wire logic             conv_done,
    input  wire logic             above,
    input  wire logic             below,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  hit_high,
    output logic                  hit_low
);

    if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
        $error("fault_counter: CNT_W must lie in 1..16");
    end

    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             dir_q;
    logic [CNT_W-1:0] limit_eff;
    logic             same_run;

    // a zero limit passes the compare on every fault just as one does, so treat it as one
    assign limit_eff = (limit == '0) ? CNT_W'(1) : limit;
    assign same_run  = (cnt_q != '0) && (dir_q == above);

    always_comb begin
        if (!(above || below)) begin
            cnt_d = '0;
        end else if (same_run) begin
            cnt_d = (cnt_q == '1) ? cnt_q : CNT_W'(cnt_q + CNT_W'(1));
        end else begin
            cnt_d = CNT_W'(1);
        end
    end

    // above takes priority when limits overlap
    assign hit_high = conv_done && above && (cnt_d >= limit_eff);
    assign hit_low  = conv_done && !above && below && (cnt_d >= limit_eff);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            dir_q <= 1'b0;
        end else if (ce && conv_done) begin
            cnt_q <= cnt_d;
            dir_q <= above;
        end
    end

endmodule // fault_counter

// File: verilog/eoc_irq_logic.sv
//
// Behaviour
// - interrupt pin low when active with sense 0, or inactive with sense 1.
// - any configuration read clears the conversion-ready mark, except when a conversion finishes in the same cycle.
// - end-of-conversion mode whenever the low-limit exponent top bits are 11b.
// - in that mode every finished conversion makes the interrupt active, except when a write dropping latched style lands in the same cycle.
// - read, non-shutdown write or alert response may make it inactive.
// - latched: high fault sets over mark, interrupt active, ready set.
// - latched: low fault sets under mark, interrupt active, ready set.
// - conversion without fault keeps marks, interrupt active, ready set.
// - read: latched clears marks; both styles deactivate interrupt, clear ready.
// - shutdown configuration write changes nothing.
// - non-shutdown write clears ready; transparent also deactivates interrupt.
// - alert response: latched deactivates interrupt; marks and ready untouched.
// - transparent: high fault sets over, clears under, interrupt active.
// - transparent: low fault clears over, sets under, interrupt active.
// - high limit should be above low limit, else marks may misbehave.
// - end-of-conversion with transparent style follows the transparent behaviour.
// - style bit 4 selects latched when 1, transparent when 0.
// - transparent style ignores and does not acknowledge alert responses.
module eoc_irq_logic (
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    input  wire eoc_irq_pkg::conv_type conv_in,
    input  wire logic                 cfg_rd_evt,
    input  wire logic                 cfg_wr_evt,
    input  wire logic [1:0]           cfg_wr_mode,
    input  wire logic                 alert_evt,
    output logic                      int_pin,
    output logic                      alert_ack,
    output logic                      over_mark,
    output logic                      under_mark,
    output logic                      conv_done_mark
);

    eoc_irq_pkg::cfg_type cfg_q;
    eoc_irq_pkg::cfg_type cfg_wr_val;
    logic                 irq_q;
    logic                 irq_d;
    logic                 over_d;
    logic                 under_d;
    logic                 ready_d;
    logic                 pready_q;
    logic                 access;
    logic                 apb_fire;
    logic                 apb_wr_cfg;
    logic                 latch_fall;
    logic                 eoc_mode;
    logic                 latched;
    logic                 run_write;
    logic                 hit_high;
    logic                 hit_low;
    logic [31:0]          rd_word;
    logic                 mapped;

    assign eoc_mode  = (cfg_q.low_limit_exp_msbs == eoc_irq_pkg::EOC_CODE);
    assign latched   = cfg_q.latch_style;
    assign run_write = cfg_wr_evt && (cfg_wr_mode != eoc_irq_pkg::MODE_SHUTDOWN);

    fault_counter #(
        .CNT_W (eoc_irq_pkg::FAULT_W)
    ) u_fault_counter (
        .clk       (clk),
        .resetn    (resetn),
        .ce        (ce),
        .conv_done (conv_in.done),
        .above     (conv_in.above),
        .below     (conv_in.below),
        .limit     (cfg_q.fault_count),
        .hit_high  (hit_high),
        .hit_low   (hit_low)
    );

    // apb slave: one wait state, data latched with pready
    assign access     = psel && penable && !pready_q;
    assign apb_fire   = psel && penable && pready_q;
    assign apb_wr_cfg = apb_fire && pwrite && (paddr == eoc_irq_pkg::CFG_OFFSET);
    assign latch_fall = apb_wr_cfg && cfg_q.latch_style && !pwdata[eoc_irq_pkg::CFG_LATCH_BIT];
    assign mapped     = (paddr == eoc_irq_pkg::CFG_OFFSET) || (paddr == eoc_irq_pkg::STATUS_OFFSET);

    assign cfg_wr_val.low_limit_exp_msbs = pwdata[eoc_irq_pkg::CFG_LE_LSB +: 2];
    assign cfg_wr_val.latch_style        = pwdata[eoc_irq_pkg::CFG_LATCH_BIT];
    assign cfg_wr_val.out_sense_sel      = pwdata[eoc_irq_pkg::CFG_SENSE_BIT];
    assign cfg_wr_val.fault_count        = pwdata[eoc_irq_pkg::CFG_FC_LSB +: eoc_irq_pkg::FAULT_W];

    always_comb begin
        rd_word = 32'h0000_0000;
        if (paddr == eoc_irq_pkg::CFG_OFFSET) begin
            rd_word[eoc_irq_pkg::CFG_LE_LSB +: 2]                  = cfg_q.low_limit_exp_msbs;
            rd_word[eoc_irq_pkg::CFG_LATCH_BIT]                    = cfg_q.latch_style;
            rd_word[eoc_irq_pkg::CFG_SENSE_BIT]                    = cfg_q.out_sense_sel;
            rd_word[eoc_irq_pkg::CFG_FC_LSB +: eoc_irq_pkg::FAULT_W] = cfg_q.fault_count;
        end else if (paddr == eoc_irq_pkg::STATUS_OFFSET) begin
            rd_word[eoc_irq_pkg::ST_OVER_BIT]  = over_mark;
            rd_word[eoc_irq_pkg::ST_UNDER_BIT] = under_mark;
            rd_word[eoc_irq_pkg::ST_READY_BIT] = conv_done_mark;
            rd_word[eoc_irq_pkg::ST_IRQ_BIT]   = irq_q;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_q <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= 32'h0000_0000;
        end else if (ce) begin
            pready_q <= access;
            pslverr  <= access && !mapped;
            if (access && !pwrite) begin
                prdata <= rd_word;
            end
        end
    end

    assign pready = pready_q;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_q <= eoc_irq_pkg::CFG_RESET;
        end else if (ce && apb_wr_cfg) begin
            cfg_q <= cfg_wr_val;
        end
    end

    // clears first, completion last, so a conversion landing on a clear wins
    always_comb begin
        over_d  = over_mark;
        under_d = under_mark;
        if (eoc_mode) begin
            if (cfg_rd_evt && latched) begin
                over_d  = 1'b0;
                under_d = 1'b0;
            end
            if (hit_high) begin
                over_d = 1'b1;
                if (!latched) begin
                    under_d = 1'b0;
                end
            end else if (hit_low) begin
                under_d = 1'b1;
                if (!latched) begin
                    over_d = 1'b0;
                end
            end
        end
    end

    always_comb begin
        irq_d = irq_q;
        if (eoc_mode) begin
            if (cfg_rd_evt) begin
                irq_d = 1'b0;
            end
            if (run_write && !latched) begin
                irq_d = 1'b0;
            end
            if (alert_evt && latched) begin
                irq_d = 1'b0;
            end
            if (conv_in.done) begin
                irq_d = 1'b1;
            end
        end
        if (latch_fall) begin
            irq_d = 1'b0;
        end
    end

    always_comb begin
        ready_d = conv_done_mark;
        if (cfg_rd_evt || run_write) begin
            ready_d = 1'b0;
        end
        if (conv_in.done) begin
            ready_d = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            over_mark  <= 1'b0;
            under_mark <= 1'b0;
        end else if (ce) begin
            over_mark  <= over_d;
            under_mark <= under_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= irq_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            conv_done_mark <= 1'b0;
        end else if (ce) begin
            conv_done_mark <= ready_d;
        end
    end

    // pin lags the state by one cycle; cheaper than a combinational pad path
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            int_pin <= 1'b1;
        end else if (ce) begin
            int_pin <= ~(irq_q ^ cfg_q.out_sense_sel);
        end
    end

    // only a pending latched interrupt answers an alert response
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alert_ack <= 1'b0;
        end else if (ce) begin
            alert_ack <= alert_evt && latched && irq_q;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    sequence s_quiet;
        !conv_in.done && !cfg_rd_evt && !alert_evt && !apb_fire;
    endsequence

    sequence s_read_eoc;
        ce && eoc_mode && cfg_rd_evt && !conv_in.done;
    endsequence

    sequence s_conv_eoc;
        ce && eoc_mode && conv_in.done;
    endsequence

    a_pin_sense: assert property (
        ce |=> (int_pin == ~($past(irq_q) ^ $past(cfg_q.out_sense_sel))))
        else $error("interrupt pin level does not follow state and sense");

    a_ready_read_clear: assert property (
        ce && cfg_rd_evt && !conv_in.done |=> !conv_done_mark)
        else $error("conversion-ready survived a configuration read");

    a_eoc_activate: assert property (
        (s_conv_eoc and (!latch_fall)) |=> irq_q && conv_done_mark)
        else $error("conversion in end-of-conversion mode did not activate");

    a_latched_high: assert property (
        (s_conv_eoc and (latched && hit_high)) |=> over_mark && $stable(under_mark))
        else $error("latched high fault marks wrong");

    a_latched_low: assert property (
        (s_conv_eoc and (latched && hit_low && !cfg_rd_evt)) |=> under_mark && $stable(over_mark))
        else $error("latched low fault marks wrong");

    a_no_fault_keep: assert property (
        (s_conv_eoc and (!hit_high && !hit_low && !cfg_rd_evt)) |=> $stable(over_mark) && $stable(under_mark))
        else $error("marks moved on a conversion without fault");

    a_read_latched: assert property (
        (s_read_eoc and latched) ##1 (s_quiet and ce) |=> !over_mark && !under_mark && !irq_q)
        else $error("latched read did not clear marks and interrupt");

    a_read_transparent: assert property (
        (s_read_eoc and (!latched)) |=> !irq_q && $stable(over_mark) && $stable(under_mark))
        else $error("transparent read handled wrong");

    a_shutdown_hold: assert property (
        (s_quiet and (ce && cfg_wr_evt && (cfg_wr_mode == eoc_irq_pkg::MODE_SHUTDOWN)))
        |=> $stable(irq_q) && $stable(conv_done_mark) && $stable(over_mark))
        else $error("shutdown write changed interrupt state");

    a_write_transparent: assert property (
        ce && eoc_mode && run_write && !latched && !conv_in.done |=> !irq_q && !conv_done_mark)
        else $error("non-shutdown write in transparent style handled wrong");

    a_alert_latched: assert property (
        ce && eoc_mode && alert_evt && latched && !conv_in.done && !cfg_rd_evt && !cfg_wr_evt
        |=> !irq_q && $stable(conv_done_mark) && $stable(over_mark))
        else $error("alert response in latched style handled wrong");

    a_trans_high: assert property (
        (s_conv_eoc and (!latched && hit_high)) |=> over_mark && !under_mark)
        else $error("transparent high fault marks wrong");

    a_trans_low: assert property (
        (s_conv_eoc and (!latched && hit_low)) |=> !over_mark && under_mark)
        else $error("transparent low fault marks wrong");

    a_no_ack_transp: assert property (
        ce && alert_evt && !latched |=> !alert_ack)
        else $error("alert acknowledged in transparent style");

    a_apb_answer: assert property (
        ce && access |=> pready ##1 !pready)
        else $error("apb answer not one cycle late");

    a_alert_ack_given: assert property (
        ce && alert_evt && latched && irq_q |=> alert_ack)
        else $error("pending latched interrupt did not answer alert");

    a_latch_fall_clear: assert property (
        ce && latch_fall |=> !irq_q)
        else $error("dropping latched style did not clear interrupt");

    a_ready_conv_set: assert property (
        ce && conv_in.done |=> conv_done_mark)
        else $error("conversion did not set ready mark");

    a_no_eoc_hold: assert property (
        ce && !eoc_mode && !latch_fall |=> $stable(irq_q) && $stable(over_mark) && $stable(under_mark))
        else $error("interrupt or marks moved outside end-of-conversion mode");

    a_apb_unmapped: assert property (
        ce && access && !mapped |=> pslverr && pready)
        else $error("unmapped access did not report an error");

endmodule // eoc_irq_logic

// File: testbench/event_host_model.sv
module event_host_model (
    input  wire logic            clk,
    output eoc_irq_pkg::conv_type conv_in,
    output logic                 cfg_rd_evt,
    output logic                 cfg_wr_evt,
    output logic [1:0]           cfg_wr_mode,
    output logic                 alert_evt
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        conv_in = '0;
        cfg_rd_evt = 1'h0;
        cfg_wr_evt = 1'h0;
        cfg_wr_mode = 2'h0;
        alert_evt = 1'h0;
    end

    // callers never flag both sides: high limit kept above low limit
    task automatic convert(input logic a, input logic b);
        @(posedge clk);
        conv_in <= '{1'h1, a, b};
        @(posedge clk);
        // levels are stale outside the pulse, so show the inverse
        conv_in <= '{1'h0, ~a, ~b};
    endtask

    task automatic cfg_read;
        @(posedge clk);
        cfg_rd_evt <= 1'h1;
        @(posedge clk);
        cfg_rd_evt <= 1'h0;
    endtask

    task automatic cfg_write(input logic [1:0] mode);
        @(posedge clk);
        cfg_wr_evt <= 1'h1;
        cfg_wr_mode <= mode;
        @(posedge clk);
        cfg_wr_evt <= 1'h0;
        cfg_wr_mode <= ~mode;
    endtask

    // alert sent whatever the style; the device decides to ignore it
    task automatic alert;
        @(posedge clk);
        alert_evt <= 1'h1;
        @(posedge clk);
        alert_evt <= 1'h0;
    endtask
endmodule // event_host_model

// File: testbench/light_sensor_eoc_interrupt_logic_bench.sv
module light_sensor_eoc_interrupt_logic_bench;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        wr;
        logic        err;
        logic [31:0] data;
    } note_type;

    logic                  clk = 1'h0;
    logic                  resetn = 1'h0;
    logic                  psel = 1'h0;
    logic                  penable = 1'h0;
    logic                  pwrite = 1'h0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    eoc_irq_pkg::conv_type conv_in;
    logic                  cfg_rd_evt;
    logic                  cfg_wr_evt;
    logic [1:0]            cfg_wr_mode;
    logic                  alert_evt;
    logic                  int_pin;
    logic                  alert_ack;
    logic                  over_mark;
    logic                  under_mark;
    logic                  conv_done_mark;
    note_type              notes[$];
    note_type              note;
    int                    failures = 0;
    int                    n_compared = 0;
    int                    n_ack = 0;
    logic [31:0]           seed;

    always #10 clk = ~clk;

    eoc_irq_logic dut (
        .clk(clk), .resetn(resetn), .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_in(conv_in), .cfg_rd_evt(cfg_rd_evt), .cfg_wr_evt(cfg_wr_evt), .cfg_wr_mode(cfg_wr_mode),
        .alert_evt(alert_evt), .int_pin(int_pin), .alert_ack(alert_ack), .over_mark(over_mark),
        .under_mark(under_mark), .conv_done_mark(conv_done_mark)
    );

    event_host_model host (
        .clk(clk), .conv_in(conv_in), .cfg_rd_evt(cfg_rd_evt), .cfg_wr_evt(cfg_wr_evt),
        .cfg_wr_mode(cfg_wr_mode), .alert_evt(alert_evt)
    );

    task automatic summarize;
        if (failures == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic compare_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected word at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic compare_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // completed transfers are checked against the oldest note
    always @(posedge clk) begin
        if (alert_ack === 1'h1)
            n_ack++;
        if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
            note = notes.pop_front();
            compare_bit(pslverr, note.err);
            if (!note.wr)
                compare_word(prdata, note.data);
        end
    end

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
        int i;
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        notes.push_back('{wr, err, d});
        @(posedge clk);
        penable <= 1'h1;
        for (i = 0; i < 20 && pready !== 1'h1; i++)
            @(posedge clk);
        if (i == 20) begin
            failures++;
            summarize();
        end
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // pin is ~(state ^ sense); status read gives marks and state
    task automatic chk(input logic o, input logic u, input logic r, input logic i, input logic s);
        repeat (2) @(posedge clk);
        compare_bit(int_pin, ~(i ^ s));
        compare_bit(over_mark, o);
        compare_bit(under_mark, u);
        compare_bit(conv_done_mark, r);
        apb(1'h0, eoc_irq_pkg::STATUS_OFFSET, {28'h0000000, i, r, u, o}, 1'h0);
    endtask

    initial begin
        seed = 32'h562DF01D;
        repeat (12) @(posedge clk);
        resetn <= 1'h1;
        apb(1'h1, 12'h008, 32'h0, 1'h1);
        apb(1'h1, eoc_irq_pkg::STATUS_OFFSET, $random(seed), 1'h0);
        chk(0, 0, 0, 0, 0);
        apb(1'h1, eoc_irq_pkg::CFG_OFFSET, 32'h00000311, 1'h0);
        host.convert(1'h1, 1'h0);
        chk(1, 0, 1, 1, 0);
        host.cfg_read();
        chk(0, 0, 0, 0, 0);
        host.convert(1'h0, 1'h1);
        chk(0, 1, 1, 1, 0);
        host.cfg_write(2'h0);
        chk(0, 1, 1, 1, 0);
        host.cfg_write(2'h2);
        chk(0, 1, 0, 1, 0);
        host.alert();
        chk(0, 1, 0, 0, 0);
        host.convert(1'h0, 1'h0);
        chk(0, 1, 1, 1, 0);
        // leaving the mode while latched needs the style bit dropped
        apb(1'h1, eoc_irq_pkg::CFG_OFFSET, 32'h00000011, 1'h0);
        apb(1'h1, eoc_irq_pkg::CFG_OFFSET, 32'h00000001, 1'h0);
        host.convert(1'h0, 1'h0);
        chk(0, 1, 1, 0, 0);
        apb(1'h1, eoc_irq_pkg::CFG_OFFSET, 32'h0000030A, 1'h0);
        host.convert(1'h1, 1'h0);
        chk(0, 1, 1, 1, 1);
        host.convert(1'h1, 1'h0);
        chk(1, 0, 1, 1, 1);
        host.cfg_read();
        chk(1, 0, 0, 0, 1);
        host.alert();
        chk(1, 0, 0, 0, 1);
        host.convert(1'h0, 1'h1);
        host.convert(1'h0, 1'h1);
        chk(0, 1, 1, 1, 1);
        host.cfg_write(2'h1);
        chk(0, 1, 0, 0, 1);
        host.cfg_write(2'h0);
        chk(0, 1, 0, 0, 1);
        compare_word(32'(n_ack), 32'h00000001);
        summarize();
    end
endmodule // light_sensor_eoc_interrupt_logic_bench
